// >>> tlic_pkg.sv
// constants shared by the two-level interrupt controller
package tlic_pkg;
  localparam int unsigned NSRC     = 64;
  localparam int unsigned NUM_W    = 6;
  localparam int unsigned LVL_W    = 4;
  localparam int unsigned MASK_W   = 5;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned LVL_REGS = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MASK  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ENNUM = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DISNUM= 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_ENH   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ENL   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_TYPH  = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_TYPL  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_LVL0  = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_LVL7  = 8'h3C;
  localparam logic [ADDR_W-1:0] OFF_FRCH  = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_FRCL  = 8'h44;
  localparam logic [ADDR_W-1:0] OFF_NVEC  = 8'h48;
  localparam logic [ADDR_W-1:0] OFF_FVEC  = 8'h4C;
  localparam logic [ADDR_W-1:0] OFF_PNDH  = 8'h50;
  localparam logic [ADDR_W-1:0] OFF_PNDL  = 8'h54;
  localparam logic [ADDR_W-1:0] OFF_NPH   = 8'h58;
  localparam logic [ADDR_W-1:0] OFF_NPL   = 8'h5C;
  localparam logic [ADDR_W-1:0] OFF_FPH   = 8'h60;
  localparam logic [ADDR_W-1:0] OFF_FPL   = 8'h64;
  localparam int unsigned CTRL_NDIS_BIT = 0;
  localparam int unsigned CTRL_FDIS_BIT = 1;
  localparam int unsigned NUM_HI_BIT    = 5;
  localparam int unsigned VEC_FOUND_BIT = 31;
  localparam logic [31:0] RESET_WORD    = 32'h0000_0000;
  typedef enum logic [1:0] {
    TLIC_IDLE = 2'b01,
    TLIC_ACK  = 2'b10
  } tlic_apb_st_t;
endpackage : tlic_pkg

// >>> tlic_en_reg.sv
// one 32-bit enable word with whole-word write and set or clear by number
`timescale 1ns/1ps
module tlic_en_reg (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // update requests
  input  wire logic        wr_word,
  input  wire logic [31:0] wdata,
  input  wire logic        set_num,
  input  wire logic        clr_num,
  input  wire logic [4:0]  num,
  // stored enables
  output logic      [31:0] q
);
  import tlic_pkg::*;
  logic [31:0] en_q;
  logic [31:0] en_d;

  always_comb begin
    en_d = en_q;
    if (wr_word) begin
      en_d = wdata;
    end
    if (set_num) begin
      en_d[num] = 1'b1;
    end
    if (clr_num) begin
      en_d[num] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      en_q <= RESET_WORD;
    end else begin
      en_q <= en_d;
    end
  end

  assign q = en_q;
endmodule : tlic_en_reg

// >>> tlic_arb.sv
// picks the highest level, then the highest number, among requesting sources
`timescale 1ns/1ps
module tlic_arb (
  // requests and their levels
  input  wire logic [63:0]  req,
  input  wire logic [255:0] lvl,
  // winner
  output logic              found,
  output logic [5:0]        num,
  output logic [3:0]        win_lvl
);
  import tlic_pkg::*;

  always_comb begin
    found   = 1'b0;
    num     = 6'h00;
    win_lvl = 4'h0;
    for (int i = 0; i < NSRC; i++) begin
      if (req[i] && (!found || lvl[i*LVL_W +: LVL_W] >= win_lvl)) begin
        found   = 1'b1;
        num     = NUM_W'(i);
        win_lvl = lvl[i*LVL_W +: LVL_W];
      end
    end
  end
endmodule : tlic_arb

// >>> tlic_top.sv
// two-level interrupt controller: apb registers, gating, arbitration, core requests
//
// Notes on behaviour
// - sixty-four request inputs merged into two core requests
// - software force bits act as pending sources
// - request needs source, controller and core enable
// - normal levels at or below mask suppressed
// - enable-by-number sets one enable bit
// - disable-by-number clears one enable bit
// - high word enables 63..32, low 31..0
// - twenty-six registers, each 32 bits wide
// - type bit routes source to fast request
// - sixteen levels, ties go to higher number
// - fast beats normal, fast order 63 down
`timescale 1ns/1ps
module tlic_top (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [tlic_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // interrupt sources
  input  wire logic [tlic_pkg::NSRC-1:0]   src_req,
  // requests to the core
  output logic                             normal_req,
  output logic                             fast_req
);
  import tlic_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  tlic_apb_st_t         st_q, st_d;
  logic                 pready_q, pready_d;
  logic                 pslverr_q, pslverr_d;
  logic [31:0]          prdata_q, prdata_d;
  logic [1:0]           ctrl_q, ctrl_d;
  logic [MASK_W-1:0]    mask_q, mask_d;
  logic [NSRC-1:0]      typ_q, typ_d;
  logic [NSRC*LVL_W-1:0] lvl_q, lvl_d;
  logic [NSRC-1:0]      frc_q, frc_d;
  logic                 nreq_q, nreq_d;
  logic                 freq_q, freq_d;

  logic                 wr_fire;
  logic                 wr_ennum;
  logic                 wr_disnum;
  logic [NSRC-1:0]      en_all;
  logic [NSRC-1:0]      pend;
  logic [NSRC-1:0]      norm_cand;
  logic [NSRC-1:0]      norm_ok;
  logic [NSRC-1:0]      fast_cand;
  logic                 norm_found, fast_found;
  logic [NUM_W-1:0]     norm_num, fast_num;
  logic [LVL_W-1:0]     norm_lvl;
  logic                 hit;
  logic [31:0]          rd_word;

  // ----------------------------------------
  // apb handshake
  // ----------------------------------------
  assign wr_fire   = psel && penable && pready_q && pwrite;
  assign wr_ennum  = wr_fire && (paddr == OFF_ENNUM);
  assign wr_disnum = wr_fire && (paddr == OFF_DISNUM);

  always_comb begin
    hit     = 1'b1;
    rd_word = RESET_WORD;
    unique case (paddr)
      OFF_CTRL:   rd_word = {30'h0000_0000, ctrl_q};
      OFF_MASK:   rd_word = {27'h000_0000, mask_q};
      OFF_ENNUM:  rd_word = RESET_WORD;
      OFF_DISNUM: rd_word = RESET_WORD;
      OFF_ENH:    rd_word = en_all[63:32];
      OFF_ENL:    rd_word = en_all[31:0];
      OFF_TYPH:   rd_word = typ_q[63:32];
      OFF_TYPL:   rd_word = typ_q[31:0];
      OFF_FRCH:   rd_word = frc_q[63:32];
      OFF_FRCL:   rd_word = frc_q[31:0];
      OFF_NVEC:   rd_word = {norm_found, 21'h00_0000, norm_lvl, norm_num};
      OFF_FVEC:   rd_word = {fast_found, 25'h000_0000, fast_num};
      OFF_PNDH:   rd_word = pend[63:32];
      OFF_PNDL:   rd_word = pend[31:0];
      OFF_NPH:    rd_word = norm_ok[63:32];
      OFF_NPL:    rd_word = norm_ok[31:0];
      OFF_FPH:    rd_word = fast_cand[63:32];
      OFF_FPL:    rd_word = fast_cand[31:0];
      default: begin
        if (paddr >= OFF_LVL0 && paddr <= OFF_LVL7 && paddr[1:0] == 2'b00) begin
          rd_word = lvl_q[32*(paddr[4:2]) +: 32];
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  always_comb begin
    st_d      = st_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = prdata_q;
    unique case (st_q)
      TLIC_IDLE: begin
        if (psel && penable) begin
          st_d      = TLIC_ACK;
          pready_d  = 1'b1;
          pslverr_d = !hit;
          prdata_d  = pwrite ? RESET_WORD : rd_word;
        end
      end
      TLIC_ACK: begin
        st_d = TLIC_IDLE;
      end
      default: begin
        st_d = TLIC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q      <= TLIC_IDLE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= RESET_WORD;
    end else begin
      st_q      <= st_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    typ_d  = typ_q;
    lvl_d  = lvl_q;
    frc_d  = frc_q;
    if (wr_fire) begin
      if (paddr == OFF_CTRL) ctrl_d = pwdata[1:0];
      if (paddr == OFF_MASK) mask_d = pwdata[MASK_W-1:0];
      if (paddr == OFF_TYPH) typ_d[63:32] = pwdata;
      if (paddr == OFF_TYPL) typ_d[31:0] = pwdata;
      if (paddr == OFF_FRCH) frc_d[63:32] = pwdata;
      if (paddr == OFF_FRCL) frc_d[31:0] = pwdata;
      for (int r = 0; r < LVL_REGS; r++) begin
        if (paddr == OFF_LVL0 + ADDR_W'(r * 4)) lvl_d[r*32 +: 32] = pwdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_q <= 2'h0;
      mask_q <= 5'h00;
      typ_q  <= 64'h0;
      lvl_q  <= '0;
      frc_q  <= 64'h0;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      typ_q  <= typ_d;
      lvl_q  <= lvl_d;
      frc_q  <= frc_d;
    end
  end

  // ----------------------------------------
  // enable words
  // ----------------------------------------
  tlic_en_reg u_en_high (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .wr_word (wr_fire && paddr == OFF_ENH),
    .wdata   (pwdata),
    .set_num (wr_ennum && pwdata[NUM_HI_BIT]),
    .clr_num (wr_disnum && pwdata[NUM_HI_BIT]),
    .num     (pwdata[4:0]),
    .q       (en_all[63:32])
  );

  tlic_en_reg u_en_low (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .wr_word (wr_fire && paddr == OFF_ENL),
    .wdata   (pwdata),
    .set_num (wr_ennum && !pwdata[NUM_HI_BIT]),
    .clr_num (wr_disnum && !pwdata[NUM_HI_BIT]),
    .num     (pwdata[4:0]),
    .q       (en_all[31:0])
  );

  // ----------------------------------------
  // gating and arbitration
  // ----------------------------------------
  assign pend      = src_req | frc_q;
  assign fast_cand = pend & en_all & typ_q;
  assign norm_cand = pend & en_all & ~typ_q;

  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      norm_ok[i] = norm_cand[i] && ({1'b0, lvl_q[i*LVL_W +: LVL_W]} > mask_q);
    end
  end

  tlic_arb u_arb_norm (
    .req     (norm_ok),
    .lvl     (lvl_q),
    .found   (norm_found),
    .num     (norm_num),
    .win_lvl (norm_lvl)
  );

  tlic_arb u_arb_fast (
    .req     (fast_cand),
    .lvl     ('0),
    .found   (fast_found),
    .num     (fast_num),
    .win_lvl ()
  );

  always_comb begin
    nreq_d = norm_found && !ctrl_q[CTRL_NDIS_BIT];
    freq_d = fast_found && !ctrl_q[CTRL_FDIS_BIT];
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      nreq_q <= 1'b0;
      freq_q <= 1'b0;
    end else begin
      nreq_q <= nreq_d;
      freq_q <= freq_d;
    end
  end

  assign normal_req = nreq_q;
  assign fast_req   = freq_q;
  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_ennum_fire;
    wr_ennum;
  endsequence
  sequence s_disnum_fire;
    wr_disnum;
  endsequence

  a_enable_set: assert property (s_ennum_fire |=> en_all[$past(pwdata[5:0])])
    else $error("enable by number did not set bit");
  a_disable_clr: assert property (s_disnum_fire |=> !en_all[$past(pwdata[5:0])])
    else $error("disable by number did not clear bit");
  a_enable_others: assert property (s_ennum_fire |=>
      ((en_all ^ $past(en_all)) & ~(64'h1 << $past(pwdata[5:0]))) == 64'h0)
    else $error("enable by number disturbed other bits");
  a_mask_hides: assert property ((norm_cand != 64'h0) && (norm_ok == 64'h0) |=> !normal_req)
    else $error("masked normal source reached core");
  a_fast_follow: assert property (fast_req == $past(|fast_cand && !ctrl_q[CTRL_FDIS_BIT]))
    else $error("fast request does not follow pending sources");
  a_norm_follow: assert property (normal_req == $past(norm_found && !ctrl_q[CTRL_NDIS_BIT]))
    else $error("normal request does not follow pending sources");
  a_no_enable: assert property ((en_all == 64'h0) [*2] |-> !normal_req && !fast_req)
    else $error("request without controller enable");
  a_fast_order: assert property (fast_found |-> fast_cand[fast_num] &&
      ((fast_cand >> fast_num) >> 1) == 64'h0)
    else $error("fast winner is not the highest source");
  a_reset_clear: assert property ($past(sys_rst) |-> en_all == 64'h0 && frc_q == 64'h0 && typ_q == 64'h0)
    else $error("configuration not cleared by reset");
  a_wr_ready: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one cycle");
endmodule : tlic_top

// >>> tlic_core_model.sv
// behavioural processor core that takes normal and fast requests
`timescale 1ns/1ps
module tlic_core_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // requests from the controller
  input  wire logic        normal_req,
  input  wire logic        fast_req,
  // return from handler
  input  wire logic        resume,
  // core state: status bit7 normal block, bit6 fast block, [4:0] mode
  output logic      [31:0] pc_q,
  output logic      [7:0]  stat_q
);
  logic [7:0]  saved_q;
  logic [31:0] link_q;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pc_q    <= 32'h0000_0100;
      stat_q  <= 8'h10;
      saved_q <= 8'h00;
      link_q  <= 32'h0000_0000;
    end else if (resume) begin
      stat_q <= saved_q;
      pc_q   <= link_q;
    end else if (fast_req && !stat_q[6]) begin
      saved_q <= stat_q;
      link_q  <= pc_q + 32'h0000_0004;
      stat_q  <= {2'b11, 1'b0, 5'b10001};
      pc_q    <= 32'h0000_001C;
    end else if (normal_req && !stat_q[7]) begin
      saved_q <= stat_q;
      link_q  <= pc_q + 32'h0000_0004;
      stat_q  <= {1'b1, stat_q[6], 1'b0, 5'b10010};
      pc_q    <= 32'h0000_0018;
    end else begin
      pc_q <= pc_q + 32'h0000_0004;
    end
  end
endmodule : tlic_core_model

// >>> two_level_irq_fiq_controller_tb.sv
// self-checking testbench for the two-level interrupt controller
`timescale 1ns/1ps
module two_level_irq_fiq_controller_tb;
  import tlic_pkg::*;
  typedef struct packed {
    logic [63:0] src;
    logic [4:0]  mask;
    logic        n;
    logic        f;
  } tlic_row_t;
  logic              clk_sys = 1'b0;
  logic              sys_rst = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [NSRC-1:0]   src_req = 64'h0;
  logic              normal_req;
  logic              fast_req;
  logic              resume = 1'b0;
  logic [31:0]       core_pc;
  logic [7:0]        core_stat;
  logic [31:0]       rd;
  logic              last_err;
  int                num_errors = 0;
  int                check_count = 0;
  tlic_row_t         rows [7];
  logic [7:0]        zoffs [5] = '{OFF_CTRL, OFF_MASK, OFF_ENH, OFF_ENL, OFF_TYPH};
  always #5 clk_sys = ~clk_sys;
  tlic_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_req(src_req), .normal_req(normal_req), .fast_req(fast_req));
  tlic_core_model core (.clk_sys(clk_sys), .sys_rst(sys_rst), .normal_req(normal_req),
    .fast_req(fast_req), .resume(resume), .pc_q(core_pc), .stat_q(core_stat));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic req_chk(input logic n, input logic f);
    repeat (3) @(posedge clk_sys);
    #1;
    chk({30'h0, normal_req, fast_req}, {30'h0, n, f});
  endtask : req_chk
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    rows[0] = '{64'h400, 5'h0, 1'b1, 1'b0};
    rows[1] = '{64'h400, 5'h2, 1'b1, 1'b0};
    rows[2] = '{64'h400, 5'h3, 1'b0, 1'b0};
    rows[3] = '{64'h800, 5'h0, 1'b0, 1'b0};
    rows[4] = '{64'h100_0000_0000, 5'h0, 1'b0, 1'b1};
    rows[5] = '{64'h100_0000_0400, 5'hF, 1'b0, 1'b1};
    rows[6] = '{64'h0, 5'h0, 1'b0, 1'b0};
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    chk({30'h0, normal_req, fast_req}, 32'h0);
    foreach (zoffs[i]) begin
      apb(1'b0, zoffs[i], 32'h0);
      chk(rd, RESET_WORD);
    end
    apb(1'b0, 8'hF0, 32'h0);
    chk({rd[30:0], last_err}, 32'h1);
    apb(1'b1, OFF_ENNUM, 32'd10);
    apb(1'b1, OFF_ENNUM, 32'd12);
    apb(1'b1, OFF_ENH, 32'h0004_0100);
    apb(1'b1, OFF_TYPH, 32'h0004_0100);
    apb(1'b1, OFF_LVL0 + 8'h04, 32'h0003_0300);
    apb(1'b1, OFF_ENNUM, 32'd45);
    apb(1'b0, OFF_ENH, 32'h0);
    chk(rd, 32'h0004_2100);
    apb(1'b1, OFF_DISNUM, 32'd45);
    apb(1'b0, OFF_ENH, 32'h0);
    chk(rd, 32'h0004_0100);
    apb(1'b0, OFF_ENL, 32'h0);
    chk(rd, 32'h0000_1400);
    foreach (rows[i]) begin
      apb(1'b1, OFF_MASK, {27'h0, rows[i].mask});
      src_req <= rows[i].src;
      req_chk(rows[i].n, rows[i].f);
    end
    chk({24'h0, core_stat}, 32'h0000_00D1);
    @(posedge clk_sys);
    resume <= 1'b1;
    @(posedge clk_sys);
    resume <= 1'b0;
    #1;
    chk({24'h0, core_stat}, 32'h0000_0092);
    @(posedge clk_sys);
    src_req <= 64'h4_0100_0000_1400;
    apb(1'b0, OFF_FVEC, 32'h0);
    chk(rd, 32'h8000_0032);
    apb(1'b0, OFF_NVEC, 32'h0);
    chk(rd, 32'h8000_00CC);
    src_req <= 64'h0;
    apb(1'b1, OFF_FRCL, 32'h0000_0400);
    req_chk(1'b1, 1'b0);
    apb(1'b1, OFF_FRCH, 32'h0000_0100);
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    req_chk(1'b0, 1'b1);
    apb(1'b1, OFF_CTRL, 32'h0000_0002);
    req_chk(1'b1, 1'b0);
    apb(1'b0, OFF_PNDH, 32'h0);
    chk(rd, 32'h0000_0100);
    apb(1'b0, OFF_NPL, 32'h0);
    chk(rd, 32'h0000_0400);
    apb(1'b0, OFF_FPH, 32'h0);
    chk(rd, 32'h0000_0100);
    apb(1'b0, OFF_LVL0 + 8'h04, 32'h0);
    chk({rd[30:0], last_err}, 32'h0006_0600);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    chk({30'h0, normal_req, fast_req}, 32'h0);
    apb(1'b0, OFF_FRCH, 32'h0);
    chk(rd, RESET_WORD);
    apb(1'b0, OFF_ENH, 32'h0);
    chk(rd, RESET_WORD);
    report_and_stop();
  end
endmodule : two_level_irq_fiq_controller_tb
